// ---- rtl/tsrc_result_config.sv ----
// tsrc_result_config: result and configuration registers with conversion sequencing
//
// How it works
// R1 - 16-bit read-only two's complement result
// R2 - result reads 8000 until first conversion
// R3 - threshold: over flag set, config read clears
// R4 - therm: over clears below hysteresis only
// R5 - threshold under flag; zero in therm
// R6 - fresh flag set on update, read clears
// R7 - bit 12 shows nonvolatile busy
// R8 - mode 00 cont, 01 off, 11 single
// R9 - period field picks cycle standby time
// R10 - averaging field, block average, reset 01
// R11 - bit 4 selects therm or threshold
// R12 - bit 3 sets output pin polarity
// R13 - bit 2 routes fresh or limit flags
// R14 - upper mode bit never reloaded nonvolatile
// R15 - config default 0220, bits 1:0 zero
// R16 - 1/8/32/64 samples; short period no standby
// R17 - host writes pointer; reads use it
// R18 - limits share the result format
// R19 - therm hysteresis is the low limit
// R20 - one-shot ends by returning to shutdown
`timescale 1ns/100ps
module tsrc_result_config
	import tsrc_pkg::*;
#(
	parameter int TICK_CYCLES = TSRC_TICK_CYCLES // clocks per 0.5 ms tick
)(
	input  wire logic        REF_CLK,      // 25 MHz clock
	input  wire logic        RESET,        // power-up reset
	input  wire logic        CLK_EN,       // freezes all state when low
	input  wire logic        GC_RESET,     // general-call reset
	input  wire logic        PTR_WR,       // pointer byte strobe
	input  wire logic [7:0]  PTR_DATA,     // pointer byte
	input  wire logic        WORD_WR,      // data word write strobe
	input  wire logic [15:0] WORD_WDATA,   // data word to write
	input  wire logic        WORD_RD,      // data word read strobe
	output logic      [15:0] RDATA,        // word read
	input  wire logic        NV_LOAD,      // reload from nonvolatile
	input  wire logic [15:0] NV_CONFIG,    // stored configuration
	input  wire logic        NV_BUSY,      // nonvolatile busy
	input  wire logic [15:0] HIGH_LIMIT,   // high limit word
	input  wire logic [15:0] LOW_LIMIT,    // low limit word
	output logic             SAMPLE_REQ,   // request samples
	input  wire logic        SAMPLE_VALID, // sample delivered
	input  wire logic [15:0] SAMPLE_DATA,  // signed sample
	output logic             ALERT_OUT     // threshold output pin
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		tsrc_state_type state;  // sequencer
		logic [7:0]     ptr;    // register pointer
		tsrc_cfg_type   cfg;    // writable configuration
		tsrc_flags_type flags;  // hardware-set flags
		logic [15:0]    result; // result word
		logic [15:0]    rdata;  // read data
		logic           alert;  // output pin level
	} tsrc_top_state_type;

	// alert pin idle level under the reset configuration
	localparam logic TSRC_ALERT_RESET = ~TSRC_CFG_RESET.output_polarity;

	localparam tsrc_top_state_type TSRC_TOP_RESET = '{
		state: TSRC_IDLE,
		ptr: TSRC_PTR_RESULT,
		cfg: TSRC_CFG_RESET,
		flags: '0,
		result: TSRC_RESULT_RESET,
		rdata: '0,
		alert: TSRC_ALERT_RESET
	};

	tsrc_top_state_type r_reg;  // registered state
	tsrc_top_state_type r_next; // next state

	logic        any_reset;   // power-up or general call
	logic        cycle_start; // restart averager and timer
	logic        avg_done;    // block average ready
	logic [15:0] avg_value;   // block average
	logic        elapsed;     // cycle period over

	assign any_reset = RESET | GC_RESET; // R2

	// ------------------------------------------------------------
	// averager and cycle timer
	// ------------------------------------------------------------
	tsrc_averager u_avg (
		.clk          (REF_CLK),
		.reset        (any_reset),
		.ce           (CLK_EN),
		.clear        (cycle_start),
		.sample_valid (SAMPLE_VALID && r_reg.state == TSRC_CONVERT),
		.sample_data  (SAMPLE_DATA),
		.avg_code     (r_reg.cfg.avg),
		.done         (avg_done),
		.average      (avg_value)
	);

	tsrc_cycle_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tmr (
		.clk         (REF_CLK),
		.reset       (any_reset),
		.ce          (CLK_EN),
		.restart     (cycle_start),
		.period_code (r_reg.cfg.period),
		.elapsed     (elapsed)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// configuration word as read back
	function automatic logic [15:0] cfg_word(input tsrc_top_state_type s,
		input logic busy);
		logic [15:0] w;
		w = '0; // R15
		w[TSRC_BIT_OVER] = s.flags.over;
		w[TSRC_BIT_UNDER] = s.flags.under & ~s.cfg.style; // R5
		w[TSRC_BIT_FRESH] = s.flags.fresh;
		w[TSRC_BIT_BUSY] = busy; // R7
		w[TSRC_CFG_HI:TSRC_CFG_LO] = s.cfg;
		return w;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic rd_cfg;        // config word read
		logic rd_res;        // result word read
		logic [1:0] mode;    // effective mode
		logic src_val;       // routed flag value
		mode = TSRC_MODE_CONT;
		src_val = 1'b0;
		rd_cfg = WORD_RD && (r_reg.ptr == TSRC_PTR_CONFIG);
		rd_res = WORD_RD && (r_reg.ptr == TSRC_PTR_RESULT);
		r_next = r_reg;
		cycle_start = 1'b0;

		// pointer kept until the next pointer byte
		if (PTR_WR) begin
			r_next.ptr = PTR_DATA; // R17
		end

		// read mux through the last pointer
		if (WORD_RD) begin
			case (r_reg.ptr)
				TSRC_PTR_RESULT: r_next.rdata = r_reg.result; // R1 R17
				TSRC_PTR_CONFIG: r_next.rdata = cfg_word(r_reg, NV_BUSY);
				default:         r_next.rdata = '0;
			endcase
		end

		// software write of the writable field
		if (WORD_WR && r_reg.ptr == TSRC_PTR_CONFIG) begin
			r_next.cfg = WORD_WDATA[TSRC_CFG_HI:TSRC_CFG_LO];
			r_next.cfg.mode = tsrc_mode_norm(WORD_WDATA[11:10]); // R8
		end else if (NV_LOAD) begin
			// nonvolatile reload keeps the upper mode bit, except that a result of 10 folds to continuous 00
			r_next.cfg = NV_CONFIG[TSRC_CFG_HI:TSRC_CFG_LO]; // R15
			r_next.cfg.mode[1] = r_reg.cfg.mode[1]; // R14
			r_next.cfg.mode = tsrc_mode_norm(r_next.cfg.mode);
		end

		// read side effects; a set below in the same cycle wins
		if (rd_cfg) begin
			if (!r_reg.cfg.style) begin
				r_next.flags.over = 1'b0; // R3
			end
			r_next.flags.under = 1'b0; // R5
			r_next.flags.fresh = 1'b0; // R6
		end
		if (rd_res) begin
			r_next.flags.fresh = 1'b0; // R6
		end

		// conversion sequencer
		mode = r_next.cfg.mode;
		case (r_reg.state)
			TSRC_IDLE: begin
				// leave shutdown on continuous or one-shot
				if (mode != TSRC_MODE_SHUT) begin // R8
					r_next.state = TSRC_CONVERT;
					cycle_start = 1'b1;
				end
			end
			TSRC_CONVERT: begin
				if (mode == TSRC_MODE_SHUT) begin
					r_next.state = TSRC_IDLE; // R8
				end else if (avg_done) begin
					// result update and limit comparison
					r_next.result = avg_value; // R1
					r_next.flags.fresh = 1'b1; // R6
					// limits compare as signed words
					if ($signed(avg_value) > $signed(HIGH_LIMIT)) begin // R18
						r_next.flags.over = 1'b1; // R3 R4
					end else if (r_reg.cfg.style
						&& $signed(avg_value) < $signed(LOW_LIMIT)) begin
						r_next.flags.over = 1'b0; // R4 R19
					end
					if (!r_reg.cfg.style
						&& $signed(avg_value) < $signed(LOW_LIMIT)) begin
						r_next.flags.under = 1'b1; // R5
					end
					if (mode == TSRC_MODE_ONE) begin
						r_next.cfg.mode = TSRC_MODE_SHUT; // R20
						r_next.state = TSRC_IDLE;
					end else begin
						r_next.state = TSRC_STANDBY;
					end
				end
			end
			TSRC_STANDBY: begin
				if (mode == TSRC_MODE_SHUT) begin
					r_next.state = TSRC_IDLE;
				end else if (elapsed || mode == TSRC_MODE_ONE) begin
					// next cycle, or an early one-shot request
					r_next.state = TSRC_CONVERT; // R9 R16
					cycle_start = 1'b1;
				end
			end
			default: begin
				r_next.state = TSRC_IDLE;
			end
		endcase

		// therm mode holds the under flag at zero
		if (r_next.cfg.style) begin
			r_next.flags.under = 1'b0; // R5 R11
		end

		// output pin routing and polarity
		src_val = r_next.cfg.src ? r_next.flags.fresh // R13
			: (r_next.flags.over | r_next.flags.under);
		r_next.alert = r_next.cfg.output_polarity ? src_val : ~src_val; // R12
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// synchronous reset; clock enable freezes everything
	always_ff @(posedge REF_CLK) begin
		if (any_reset) begin
			r_reg <= TSRC_TOP_RESET; // R2 R15
		end else if (CLK_EN) begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign RDATA = r_reg.rdata;
	assign ALERT_OUT = r_reg.alert;
	assign SAMPLE_REQ = (r_reg.state == TSRC_CONVERT);

endmodule

// ---- common/tsrc_pkg.sv ----
// tsrc_pkg: constants, types and helpers shared by the temperature result/config logic
package tsrc_pkg;

	// ------------------------------------------------------------
	// register pointers and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  TSRC_PTR_RESULT   = 8'h00;   // result word
	localparam logic [7:0]  TSRC_PTR_CONFIG   = 8'h01;   // configuration word
	localparam logic [15:0] TSRC_RESULT_RESET = 16'h8000; // minus 256 degrees
	localparam logic [15:0] TSRC_CONFIG_RESET = 16'h0220; // factory setting

	// ------------------------------------------------------------
	// configuration field positions
	// ------------------------------------------------------------
	localparam int TSRC_BIT_OVER   = 15; // over-limit flag
	localparam int TSRC_BIT_UNDER  = 14; // under-limit flag
	localparam int TSRC_BIT_FRESH  = 13; // result-fresh flag
	localparam int TSRC_BIT_BUSY   = 12; // nonvolatile busy
	localparam int TSRC_CFG_HI     = 11; // top of writable field
	localparam int TSRC_CFG_LO     = 2;  // bottom of writable field

	// ------------------------------------------------------------
	// conversion mode codes
	// ------------------------------------------------------------
	localparam logic [1:0] TSRC_MODE_CONT  = 2'h0; // continuous
	localparam logic [1:0] TSRC_MODE_SHUT  = 2'h1; // shutdown
	localparam logic [1:0] TSRC_MODE_ALIAS = 2'h2; // acts as continuous
	localparam logic [1:0] TSRC_MODE_ONE   = 2'h3; // one-shot

	// ------------------------------------------------------------
	// timing: the cycle timer counts half-millisecond ticks
	// ------------------------------------------------------------
	localparam int TSRC_CLK_PERIOD_NS = 40;     // 25 MHz reference
	localparam int TSRC_TICK_NS       = 500000; // 0.5 ms tick
	localparam int TSRC_TICK_CYCLES   = TSRC_TICK_NS / TSRC_CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	// writable configuration, packed in the order of bits 11:2
	typedef struct packed {
		logic [1:0] mode;   // conversion_mode
		logic [2:0] period; // cycle_period_select
		logic [1:0] avg;    // sample_averaging
		logic       style;  // comparator_style_select, 1 = therm
		logic       output_polarity;    // output_polarity, 1 = active high
		logic       src;    // output_source_select, 1 = fresh flag
	} tsrc_cfg_type;

	// hardware-set status flags
	typedef struct packed {
		logic over;
		logic under;
		logic fresh;
	} tsrc_flags_type;

	// conversion sequencer states
	typedef enum logic [1:0] {TSRC_IDLE, TSRC_CONVERT, TSRC_STANDBY} tsrc_state_type;

	localparam tsrc_cfg_type TSRC_CFG_RESET = TSRC_CONFIG_RESET[TSRC_CFG_HI:TSRC_CFG_LO];

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// averaging code to log2 of the sample count (1, 8, 32, 64)
	function automatic logic [2:0] tsrc_avg_shift(input logic [1:0] code);
		case (code)
			2'h0:    tsrc_avg_shift = 3'h0;
			2'h1:    tsrc_avg_shift = 3'h3;
			2'h2:    tsrc_avg_shift = 3'h5;
			default: tsrc_avg_shift = 3'h6;
		endcase
	endfunction

	// cycle period code to length in ticks (15.5 ms up to 16 s)
	function automatic logic [15:0] tsrc_period_ticks(input logic [2:0] code);
		case (code)
			3'h0:    tsrc_period_ticks = 16'h001f;
			3'h1:    tsrc_period_ticks = 16'h00fa;
			3'h2:    tsrc_period_ticks = 16'h01f4;
			3'h3:    tsrc_period_ticks = 16'h03e8;
			3'h4:    tsrc_period_ticks = 16'h07d0;
			3'h5:    tsrc_period_ticks = 16'h1f40;
			3'h6:    tsrc_period_ticks = 16'h3e80;
			default: tsrc_period_ticks = 16'h7d00;
		endcase
	endfunction

	// the alias of continuous mode is stored and read as continuous
	function automatic logic [1:0] tsrc_mode_norm(input logic [1:0] code);
		tsrc_mode_norm = (code == TSRC_MODE_ALIAS) ? TSRC_MODE_CONT : code;
	endfunction

endpackage

// ---- rtl/tsrc_averager.sv ----
// tsrc_averager: block averager of conversion samples
`timescale 1ns/100ps
module tsrc_averager
	import tsrc_pkg::*;
(
	input  wire logic        clk,          // reference clock
	input  wire logic        reset,        // synchronous reset
	input  wire logic        ce,           // clock enable
	input  wire logic        clear,        // restart a block
	input  wire logic        sample_valid, // one sample taken
	input  wire logic [15:0] sample_data,  // signed sample
	input  wire logic [1:0]  avg_code,     // averaging select
	output logic             done,         // one-cycle block end
	output logic      [15:0] average       // block mean
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic signed [21:0] acc;   // running sum of the block
		logic        [6:0]  count; // samples so far
		logic               done;  // block end pulse
		logic        [15:0] avg;   // last mean
	} tsrc_avg_state_type;

	tsrc_avg_state_type r_reg;  // registered state
	tsrc_avg_state_type r_next; // next state

	// accumulate, then divide by shifting when the block is full
	always_comb begin
		logic signed [21:0] sum;
		logic        [2:0]  shift;
		sum = r_reg.acc + 22'(signed'(sample_data));
		shift = tsrc_avg_shift(avg_code);
		r_next = r_reg;
		r_next.done = 1'b0;
		if (clear) begin
			r_next.acc = '0;
			r_next.count = '0;
		end else if (sample_valid) begin
			if (r_reg.count + 7'h01 >= (7'h01 << shift)) begin // R10 R16
				r_next.avg = 16'(sum >>> shift);
				r_next.done = 1'b1;
				r_next.acc = '0; // R10
				r_next.count = '0;
			end else begin
				r_next.acc = sum;
				r_next.count = r_reg.count + 7'h01;
			end
		end
	end

	// register the state; reset and enable
	always_ff @(posedge clk) begin
		if (reset) begin
			r_reg <= '{acc: '0, count: '0, done: 1'b0, avg: TSRC_RESULT_RESET};
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	assign done = r_reg.done;
	assign average = r_reg.avg;

endmodule

// ---- rtl/tsrc_cycle_timer.sv ----
// tsrc_cycle_timer: measures time since the start of a conversion cycle
`timescale 1ns/100ps
module tsrc_cycle_timer
	import tsrc_pkg::*;
#(
	parameter int TICK_CYCLES = TSRC_TICK_CYCLES // clocks per 0.5 ms
)(
	input  wire logic       clk,         // reference clock
	input  wire logic       reset,       // synchronous reset
	input  wire logic       ce,          // clock enable
	input  wire logic       restart,     // cycle starts now
	input  wire logic [2:0] period_code, // cycle period select
	output logic            elapsed      // period has passed
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] pre;   // clocks within a tick
		logic [15:0] ticks; // ticks since restart
	} tsrc_tmr_state_type;

	tsrc_tmr_state_type r_reg;  // registered state
	tsrc_tmr_state_type r_next; // next state

	// prescaler and saturating tick count
	always_comb begin
		r_next = r_reg;
		if (restart) begin
			r_next = '0;
		end else if (r_reg.pre >= 16'(TICK_CYCLES - 1)) begin
			r_next.pre = '0;
			if (r_reg.ticks != 16'hffff) begin
				r_next.ticks = r_reg.ticks + 16'h0001;
			end
		end else begin
			r_next.pre = r_reg.pre + 16'h0001;
		end
	end

	// register the state
	always_ff @(posedge clk) begin
		if (reset) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	// standby ends when the period is over; a period shorter than
	// the active time has already passed when the block ends
	assign elapsed = (r_reg.ticks >= tsrc_period_ticks(period_code)); // R9 R16

endmodule

// ---- verification/tsrc_result_config_sva.sv ----
// checker of the register port and conversion behaviour at the top ports
`timescale 1ns/100ps
module tsrc_result_config_sva
(
	input wire logic        REF_CLK,      // reference clock
	input wire logic        RESET,        // power-up reset
	input wire logic        CLK_EN,       // clock enable
	input wire logic        GC_RESET,     // general-call reset
	input wire logic        PTR_WR,       // pointer strobe
	input wire logic [7:0]  PTR_DATA,     // pointer byte
	input wire logic        WORD_WR,      // word write strobe
	input wire logic [15:0] WORD_WDATA,   // word written
	input wire logic        WORD_RD,      // word read strobe
	input wire logic [15:0] RDATA,        // word read
	input wire logic        NV_BUSY,      // nonvolatile busy
	input wire logic        NV_LOAD,      // nonvolatile reload
	input wire logic        SAMPLE_REQ,   // sample request
	input wire logic        SAMPLE_VALID, // sample strobe
	input wire logic        ALERT_OUT     // threshold pin
);
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	logic [7:0]  ptr_reg;   // pointer as the host left it
	logic        virgin_reg; // no sample taken since reset
	logic [15:0] wd_reg;    // last word written
	logic        cfg_rd;    // taken read of the configuration
	logic        cfg_wr;    // taken write of the configuration

	assign cfg_rd = WORD_RD && CLK_EN && ptr_reg == 8'h01;
	assign cfg_wr = WORD_WR && CLK_EN && ptr_reg == 8'h01;

	// follows the pointer, writes and first sample
	always_ff @(posedge REF_CLK) begin
		if (RESET || GC_RESET) begin
			ptr_reg    <= 8'h00;
			virgin_reg <= 1'b1;
		end else if (CLK_EN) begin
			if (PTR_WR) ptr_reg <= PTR_DATA;
			if (SAMPLE_VALID && SAMPLE_REQ) virgin_reg <= 1'b0;
			if (WORD_WR) wd_reg <= WORD_WDATA;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET || GC_RESET);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	reset_outputs_a: assert property (($fell(RESET) || $fell(GC_RESET)) |->
		RDATA == 16'h0000 && ALERT_OUT && !SAMPLE_REQ) else $error("outputs not at reset");
	start_convert_a: assert property ($fell(RESET) && CLK_EN && !NV_LOAD |=> SAMPLE_REQ)
		else $error("no conversion after reset");
	read_hold_a: assert property (!(WORD_RD && CLK_EN) |=> $stable(RDATA))
		else $error("read data moved without a read");
	result_reset_a: assert property (WORD_RD && CLK_EN && ptr_reg == 8'h00 && virgin_reg
		|=> RDATA == 16'h8000) else $error("result not at reset value");
	unused_bits_a: assert property (cfg_rd |=> RDATA[1:0] == 2'h0)
		else $error("unused bits not zero");
	busy_bit_a: assert property (cfg_rd |=> RDATA[12] == $past(NV_BUSY))
		else $error("busy bit wrong");
	mode_alias_a: assert property (cfg_rd |=> RDATA[11:10] != 2'h2)
		else $error("mode alias read back");
	flags_clear_a: assert property (!SAMPLE_VALID [*3] ##0 cfg_rd ##1 !SAMPLE_VALID [*2]
		##2 cfg_rd |=> RDATA[14:13] == 2'h0) else $error("flags not cleared by read");
	cfg_write_a: assert property (cfg_wr ##1 (!WORD_WR && !NV_LOAD) [*3]
		##1 (cfg_rd && !WORD_WR) |=> RDATA[9:2] == wd_reg[9:2])
		else $error("written fields not read back");
endmodule

bind tsrc_result_config tsrc_result_config_sva chk (.REF_CLK(REF_CLK), .RESET(RESET),
	.CLK_EN(CLK_EN), .GC_RESET(GC_RESET), .PTR_WR(PTR_WR), .PTR_DATA(PTR_DATA),
	.WORD_WR(WORD_WR), .WORD_WDATA(WORD_WDATA), .WORD_RD(WORD_RD), .RDATA(RDATA),
	.NV_BUSY(NV_BUSY), .NV_LOAD(NV_LOAD), .SAMPLE_REQ(SAMPLE_REQ), .SAMPLE_VALID(SAMPLE_VALID),
	.ALERT_OUT(ALERT_OUT));

// ---- verification/tsrc_host_model.sv ----
// host controller model: selects a register and moves one word
`timescale 1ns/100ps
module tsrc_host_model
(
	input  wire logic        clk,        // reference clock
	input  wire logic [15:0] rdata,      // word read
	output logic             ptr_wr,     // pointer strobe
	output logic       [7:0] ptr_data,   // pointer byte
	output logic             word_wr,    // write strobe
	output logic      [15:0] word_wdata, // write word
	output logic             word_rd     // read strobe
);
	// idle bus at time zero
	initial begin
		ptr_wr = 1'b0;
		ptr_data = 8'h00;
		word_wr = 1'b0;
		word_wdata = 16'h0000;
		word_rd = 1'b0;
	end

	// pointer first, optional idle gap, then one word
	task automatic access(input logic [7:0] ptr, input logic wr, input logic [15:0] wd,
		input int gap, output logic [15:0] rd);
		@(posedge clk);
		ptr_wr   <= 1'b1;
		ptr_data <= ptr;
		@(posedge clk);
		ptr_wr <= 1'b0;
		repeat (gap) @(posedge clk);
		word_wr    <= wr;
		word_rd    <= !wr;
		word_wdata <= wd;
		@(posedge clk);
		word_wr <= 1'b0;
		word_rd <= 1'b0;
		@(posedge clk);
		rd = rdata;
	endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the result and configuration registers
`timescale 1ns/100ps
module tb_top
	import tsrc_pkg::*;
;
	typedef struct packed {
		logic [7:0]  ptr;   // register pointer
		logic [15:0] wd;    // word written
		logic [15:0] exp;   // word read back
		logic        alert; // pin level after
	} tsrc_row_type;

	localparam tsrc_row_type ROWS [7] = '{
		'{8'h01, 16'h0220, TSRC_CONFIG_RESET, 1'b1},
		'{8'h01, 16'hf8fc, 16'h00fc, 1'b0},
		'{8'h01, 16'h0403, 16'h0400, 1'b1},
		'{8'h01, 16'h0c84, 16'h0c84, 1'b1},
		'{8'h01, 16'h0358, 16'h0358, 1'b0},
		'{8'h00, 16'h1234, TSRC_RESULT_RESET, 1'b0},
		'{8'h05, 16'h1234, 16'h0000, 1'b0}};

	logic        ref_clk = 1'b0;      // clock
	logic        reset = 1'b1;        // power-up reset
	logic        gc_reset = 1'b0;     // general-call reset
	logic        clk_en = 1'b1;       // clock enable
	logic        nv_load = 1'b0;      // reload strobe
	logic        nv_busy = 1'b0;      // busy level
	logic [15:0] nv_config = 16'h0000; // stored word
	logic [15:0] high_limit = 16'h1000; // high limit
	logic [15:0] low_limit = 16'h0100;  // low limit
	logic        sample_valid = 1'b0; // sample strobe
	logic [15:0] sample_data = 16'h0000; // sample
	logic        ptr_wr, word_wr, word_rd, sample_req, alert_out;
	logic [7:0]  ptr_data;
	logic [15:0] word_wdata, rdata, rd;
	int          fails = 0;
	int          check_count = 0;

	always #20 ref_clk = ~ref_clk;

	tsrc_result_config #(.TICK_CYCLES(4)) uut (.REF_CLK(ref_clk), .RESET(reset),
		.CLK_EN(clk_en), .GC_RESET(gc_reset), .PTR_WR(ptr_wr), .PTR_DATA(ptr_data),
		.WORD_WR(word_wr), .WORD_WDATA(word_wdata), .WORD_RD(word_rd), .RDATA(rdata),
		.NV_LOAD(nv_load), .NV_CONFIG(nv_config), .NV_BUSY(nv_busy),
		.HIGH_LIMIT(high_limit), .LOW_LIMIT(low_limit), .SAMPLE_REQ(sample_req),
		.SAMPLE_VALID(sample_valid), .SAMPLE_DATA(sample_data), .ALERT_OUT(alert_out));

	tsrc_host_model host (.clk(ref_clk), .rdata(rdata), .ptr_wr(ptr_wr),
		.ptr_data(ptr_data), .word_wr(word_wr), .word_wdata(word_wdata), .word_rd(word_rd));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one host word transfer into rd
	task automatic rw(input logic [7:0] p, input logic w, input logic [15:0] d);
		host.access(p, w, d, 0, rd);
	endtask

	// wait for a request, then n samples: d first, zeros after
	task automatic give(input logic [15:0] d, input int n);
		int i;
		i = 0;
		do begin
			@(negedge ref_clk);
			i++;
		end while (sample_req !== 1'b1 && i < 5000);
		if (sample_req !== 1'b1) begin
			fails++; // wait limit ran out
		end
		for (int k = 0; k < n; k++) begin
			@(posedge ref_clk);
			sample_valid <= 1'b1;
			sample_data  <= (k == 0) ? d : 16'h0000;
		end
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// verdict and end of run
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		#400000;
		fails++;
		summarize();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		// table of writes and read-backs
		for (int r = 0; r < 7; r++) begin
			host.access(ROWS[r].ptr, 1'b1, ROWS[r].wd, r % 2, rd);
			host.access(ROWS[r].ptr, 1'b0, 16'h0000, r % 2, rd);
			check(rd, ROWS[r].exp);
			check({15'h0, alert_out}, {15'h0, ROWS[r].alert});
		end
		$display("test table done");
		// threshold crossing, active-low pin
		rw(8'h01, 1'b1, 16'h0000);
		give(16'h2000, 1);
		check({15'h0, alert_out}, 16'h0000);
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'ha000);
		rw(8'h00, 1'b0, 16'h0000);
		check(rd, 16'h2000);
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'h0000);
		check({15'h0, alert_out}, 16'h0001);
		$display("test threshold done");
		// block of eight with floor rounding, under limit
		rw(8'h01, 1'b1, 16'h0020);
		give(16'hfffc, 8);
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'h6020);
		rw(8'h00, 1'b0, 16'h0000);
		check(rd, 16'hffff);
		$display("test averaging done");
		// therm mode: read keeps the flag, low limit clears it
		rw(8'h01, 1'b1, 16'h0010);
		give(16'h2000, 1);
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'ha010);
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'h8010);
		give(16'h0000, 1);
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'h2010);
		$display("test therm done");
		// one-shot falls back to shutdown
		rw(8'h01, 1'b1, 16'h0c00);
		give(16'h0123, 1);
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'h2400);
		rw(8'h00, 1'b0, 16'h0000);
		check(rd, 16'h0123);
		$display("test one-shot done");
		// general-call reset, then nonvolatile reload
		@(posedge ref_clk);
		gc_reset <= 1'b1;
		@(posedge ref_clk);
		gc_reset <= 1'b0;
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, TSRC_CONFIG_RESET);
		rw(8'h00, 1'b0, 16'h0000);
		check(rd, TSRC_RESULT_RESET);
		@(posedge ref_clk);
		nv_config <= 16'h0e5c;
		nv_load   <= 1'b1;
		nv_busy   <= 1'b1;
		@(posedge ref_clk);
		nv_load <= 1'b0;
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'h165c);
		nv_busy <= 1'b0;
		$display("test reset and reload done");
		// clock enable low freezes pointer and read data
		clk_en <= 1'b0;
		rw(8'h00, 1'b0, 16'h0000);
		check(rd, 16'h165c);
		clk_en <= 1'b1;
		rw(8'h01, 1'b0, 16'h0000);
		check(rd, 16'h065c);
		$display("test clock enable done");
		summarize();
	end
endmodule
